//--- design/sdd_pkg.sv
/*
 * Holds the shared constants of the four-digit segment decoder and driver:
 * register offsets, field positions, reset values, timing counts and glyph tables.
 * Assumes a 250 MHz system clock and a classic Wishbone register bus.
 */
// Operation
// - Address 00,01,10,11 selects digit four,three,two,one.
// - Both selects low: capture data and address.
// - Select rising: decode latched data into addressed digit.
// - Timebase low: release plane, follow external plane.
// - Plane frequency is timebase divided by 128.
// - Timebase lows under one microsecond are ignored.
// - LED style: brightness high lights segments, low blanks all.
// - Four-bit positive binary value, bit zero lowest.
// - Hex variant shows glyphs 0-9 and A-F.
// - Restricted variant: digits, dash, E, H, L, P, blank.
// - Rising digit strobe stores decoded value there.
package sdd_pkg;
    // Register byte offsets.
    localparam logic [3:0] SDD_CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] SDD_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] SDD_DIGITS_OFFSET = 4'h8;
    // Control fields and their reset values.
    localparam int         SDD_CTRL_HEX_BIT  = 0;
    localparam int         SDD_CTRL_LCD_BIT  = 1;
    localparam int         SDD_CTRL_BUS_BIT  = 2;
    localparam logic [2:0] SDD_CTRL_RESET    = 3'h3;
    // Status fields.
    localparam int         SDD_STAT_SLAVE_BIT = 0;
    localparam int         SDD_STAT_PLANE_BIT = 1;
    // Timing: clock period and the shortest low that counts as a disable.
    localparam int SDD_CLK_PERIOD_NS = 4;
    localparam int SDD_LOW_IGNORE_NS = 1000;
    localparam int SDD_LOW_CYCLES    = SDD_LOW_IGNORE_NS / SDD_CLK_PERIOD_NS;
    localparam int SDD_PLANE_DIVIDE  = 128;
    localparam int SDD_PLANE_HALF    = SDD_PLANE_DIVIDE / 2;
    // Glyph tables, segment a in bit 0 through segment g in bit 6.
    localparam logic [6:0] SDD_HEX_GLYPH [16] = '{
        7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
        7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    localparam logic [6:0] SDD_CODEB_GLYPH [16] = '{
        7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
        7'h7F, 7'h6F, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
endpackage

//--- design/sdd_plane_if.sv
/*
 * Carries the backplane state from the timebase block to the top module.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface sdd_plane_if;
    logic plane_level;  // Current backplane level seen by the segments.
    logic slave_mode;   // High while the plane follows the external pin.
    modport source (output plane_level, output slave_mode);
    modport sink   (input  plane_level, input  slave_mode);
endinterface
`default_nettype wire

//--- design/sdd_glyph_decoder.sv
/*
 * Combinational glyph decoder for one four-bit value.
 * Assumes the caller registers the result; no state is held here.
 */
`timescale 1ns/10ps
`default_nettype none
module sdd_glyph_decoder (
    input  wire logic [3:0] value,
    input  wire logic       hex_sel,
    output logic      [6:0] glyph
);
    // The value is plain positive binary, bit zero least significant.
    always_comb begin
        if (hex_sel) begin
            glyph = sdd_pkg::SDD_HEX_GLYPH[value];
        end else begin
            glyph = sdd_pkg::SDD_CODEB_GLYPH[value];
        end
    end
endmodule
`default_nettype wire

//--- design/sdd_timebase.sv
/*
 * Backplane generator: divides the timebase pin by 128 and detects a held-low
 * timebase, which hands the plane over to the external common-plane pin.
 * Assumes the timebase pin is synchronous to sys_clk and far slower than it.
 */
`timescale 1ns/10ps
`default_nettype none
module sdd_timebase (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic timebase_pin,
    input  wire logic common_plane_in,
    sdd_plane_if.source plane
);
    logic       tb_prev_reg;   // Timebase level one cycle ago.
    logic [8:0] low_cnt_reg;   // Length of the current low run.
    logic [5:0] div_cnt_reg;   // Timebase rising edges within a half period.
    logic       own_level_reg; // Internally divided plane level.
    logic       slave_reg;     // Disable detected.
    logic       level_reg;     // Plane level handed to the segments.

    // Short lows are only counted; the mode changes once the run is long.
    // A full-swing overdrive with brief lows therefore never slaves the part.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            low_cnt_reg <= 9'h000;
            slave_reg   <= 1'b0;
        end else if (clk_en) begin
            if (timebase_pin) begin
                low_cnt_reg <= 9'h000;
                slave_reg   <= 1'b0;
            end else if (low_cnt_reg >= 9'(sdd_pkg::SDD_LOW_CYCLES - 1)) begin
                slave_reg <= 1'b1;
            end else begin
                low_cnt_reg <= low_cnt_reg + 9'h001;
            end
        end
    end

    // Toggle the own plane every 64 timebase rising edges, a divide by 128.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tb_prev_reg   <= 1'b0;
            div_cnt_reg   <= 6'h00;
            own_level_reg <= 1'b0;
        end else if (clk_en) begin
            tb_prev_reg <= timebase_pin;
            if (timebase_pin && !tb_prev_reg) begin
                div_cnt_reg <= div_cnt_reg + 6'h01;
                if (div_cnt_reg == 6'(sdd_pkg::SDD_PLANE_HALF - 1)) begin
                    own_level_reg <= ~own_level_reg;
                end
            end
        end
    end

    // In slave mode the segments follow the external plane directly.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            level_reg <= 1'b0;
        end else if (clk_en) begin
            level_reg <= slave_reg ? common_plane_in : own_level_reg;
        end
    end

    assign plane.plane_level = level_reg;
    assign plane.slave_mode  = slave_reg;
endmodule
`default_nettype wire

//--- design/sdd_top.sv
/*
 * Four-digit seven-segment decoder and driver with two loading schemes,
 * multiplexed digit strobes or a processor port with two active-low selects,
 * and LCD or LED output styles, configured over classic Wishbone.
 * Assumes all pins are synchronous to sys_clk and held for several cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module sdd_top (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // Classic Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Character value.
    input  wire logic        value_bit_zero,
    input  wire logic        value_bit_one,
    input  wire logic        value_bit_two,
    input  wire logic        value_bit_three,
    // Multiplexed loading strobes, active high.
    input  wire logic        digit_one_strobe,
    input  wire logic        digit_two_strobe,
    input  wire logic        digit_three_strobe,
    input  wire logic        digit_four_strobe,
    // Processor loading port.
    input  wire logic        digit_addr_low,
    input  wire logic        digit_addr_high,
    input  wire logic        bus_select_a_n,
    input  wire logic        bus_select_b_n,
    // Timebase, common plane and brightness.
    input  wire logic        timebase_pin,
    input  wire logic        common_plane_in,
    output logic             common_plane_out,
    output logic             common_plane_oe,
    input  wire logic        brightness,
    // Segment drives, digit one in bits 6:0, segment a lowest.
    output logic      [27:0] seg_out
);
    sdd_plane_if plane_bus ();

    logic [2:0]  ctrl_reg;        // Decoder, output and loading style.
    logic [6:0]  glyph_reg [4];   // Output latches, index 0 is digit one.
    logic [3:0]  in_value_reg;    // Input latch for the processor port.
    logic [1:0]  in_addr_reg;     // Input latch for the digit address.
    logic        sel_low_reg;     // Both selects were low last cycle in processor loading style.
    logic [3:0]  strobe_prev_reg; // Strobe levels one cycle ago.
    logic [27:0] seg_reg;         // Registered segment drives.
    logic        plane_out_reg;   // Registered plane pin level.
    logic        plane_oe_reg;    // Registered plane pin enable.
    logic        ack_reg;         // Wishbone acknowledge.
    logic [31:0] rdata_reg;       // Wishbone read data.

    logic [3:0]  pin_value;       // Value pins gathered into one word.
    logic [3:0]  strobes;         // Strobe pins, index 0 is digit one.
    logic        sel_low;         // Both selects low now.
    logic        commit;          // A select has just risen after a capture.
    logic [1:0]  commit_digit;    // Digit index named by the latched address.
    logic [6:0]  live_glyph;      // Decode of the value pins.
    logic [6:0]  latched_glyph;   // Decode of the input latch.
    logic [27:0] lit;             // Flattened output latches.
    logic        wb_req;          // New bus request this cycle.

    assign pin_value = {value_bit_three, value_bit_two, value_bit_one, value_bit_zero};
    assign strobes   = {digit_four_strobe, digit_three_strobe, digit_two_strobe, digit_one_strobe};
    assign sel_low   = !bus_select_a_n && !bus_select_b_n;
    // Either select rising ends the write, so no longer both low is the trigger.
    assign commit    = sel_low_reg && !sel_low;
    // Address 00 names digit four and 11 names digit one, so the index inverts.
    assign commit_digit = ~in_addr_reg;
    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;

    sdd_glyph_decoder live_dec (
        .value   (pin_value),
        .hex_sel (ctrl_reg[sdd_pkg::SDD_CTRL_HEX_BIT]),
        .glyph   (live_glyph)
    );

    sdd_glyph_decoder latch_dec (
        .value   (in_value_reg),
        .hex_sel (ctrl_reg[sdd_pkg::SDD_CTRL_HEX_BIT]),
        .glyph   (latched_glyph)
    );

    sdd_timebase timebase (
        .sys_clk         (sys_clk),
        .reset           (reset),
        .clk_en          (clk_en),
        .timebase_pin    (timebase_pin),
        .common_plane_in (common_plane_in),
        .plane           (plane_bus.source)
    );

    // Control register; byte lane zero carries all its fields.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_reg <= sdd_pkg::SDD_CTRL_RESET;
        end else if (clk_en) begin
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == sdd_pkg::SDD_CTRL_OFFSET) begin
                ctrl_reg <= wb_dat_i[2:0];
            end
        end
    end

    // Bus answer one cycle after the request, unmapped reads return zero.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_reg <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    sdd_pkg::SDD_CTRL_OFFSET: begin
                        rdata_reg <= {29'h0000_0000, ctrl_reg};
                    end
                    sdd_pkg::SDD_STATUS_OFFSET: begin
                        rdata_reg <= {30'h0000_0000, plane_bus.plane_level, plane_bus.slave_mode};
                    end
                    sdd_pkg::SDD_DIGITS_OFFSET: begin
                        rdata_reg <= {4'h0, lit};
                    end
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Input latches are transparent while both selects are low in processor loading style.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            in_value_reg <= 4'h0;
            in_addr_reg  <= 2'h0;
            sel_low_reg  <= 1'b0;
        end else if (clk_en) begin
            sel_low_reg <= sel_low && ctrl_reg[sdd_pkg::SDD_CTRL_BUS_BIT];
            if (sel_low && ctrl_reg[sdd_pkg::SDD_CTRL_BUS_BIT]) begin
                in_value_reg <= pin_value;
                in_addr_reg  <= {digit_addr_high, digit_addr_low};
            end
        end
    end

    // Output latches change only on a strobe edge or a select commit.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            strobe_prev_reg <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                glyph_reg[i] <= 7'h00;
            end
        end else if (clk_en) begin
            strobe_prev_reg <= strobes;
            if (ctrl_reg[sdd_pkg::SDD_CTRL_BUS_BIT]) begin
                if (commit) begin
                    glyph_reg[commit_digit] <= latched_glyph;
                end
            end else begin
                for (int i = 0; i < 4; i++) begin
                    if (strobes[i] && !strobe_prev_reg[i]) begin
                        glyph_reg[i] <= live_glyph;
                    end
                end
            end
        end
    end

    assign lit = {glyph_reg[3], glyph_reg[2], glyph_reg[1], glyph_reg[0]};

    // Segment drive: LCD style is exclusive-or with the plane so lit segments sit
    // in antiphase and unlit ones in phase; LED style gates with brightness.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seg_reg <= 28'h000_0000;
        end else if (clk_en) begin
            if (ctrl_reg[sdd_pkg::SDD_CTRL_LCD_BIT]) begin
                seg_reg <= lit ^ {28{plane_bus.plane_level}};
            end else begin
                seg_reg <= brightness ? lit : 28'h000_0000;
            end
        end
    end

    // The plane driver is released while slaved, and in LED style.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            plane_out_reg <= 1'b0;
            plane_oe_reg  <= 1'b0;
        end else if (clk_en) begin
            plane_out_reg <= plane_bus.plane_level;
            plane_oe_reg  <= ctrl_reg[sdd_pkg::SDD_CTRL_LCD_BIT] && !plane_bus.slave_mode;
        end
    end

    assign wb_dat_o         = rdata_reg;
    assign wb_ack_o         = ack_reg;
    assign seg_out          = seg_reg;
    assign common_plane_out = plane_out_reg;
    assign common_plane_oe  = plane_oe_reg;
endmodule
`default_nettype wire

//--- verification/sdd_props.sv
/* Port checker for sdd_top.
   Assumes clk_en stays high and a single sys_clk domain. */
`timescale 1ns/10ps
`default_nettype none
module sdd_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        timebase_pin,
    input wire logic        common_plane_in,
    input wire logic        common_plane_out,
    input wire logic        common_plane_oe,
    input wire logic        brightness,
    input wire logic [27:0] seg_out
);
    logic [2:0] ctrl_reg; // Shadow control register.
    logic [8:0] low_reg;  // Timebase low run, saturating.
    logic [7:0] rise_reg; // Timebase rises since the plane last moved.
    logic [1:0] seen_reg; // Driven plane moves in a row, saturating at two.
    logic       tb_reg;   // Timebase one sample back.
    logic       pl_reg;   // Plane one sample back.
    // Follow control writes on the edge that takes them.
    always_ff @(posedge sys_clk) begin
        if (reset)
            ctrl_reg <= sdd_pkg::SDD_CTRL_RESET;
        else if (clk_en && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0)
            ctrl_reg <= wb_dat_i[2:0];
    end
    // A high sample restarts the low run.
    always_ff @(posedge sys_clk) begin
        if (reset || timebase_pin)
            low_reg <= 9'h000;
        else if (low_reg != 9'h1FF)
            low_reg <= low_reg + 9'h001;
    end
    // Two moves are skipped: the divider phase is not visible here, and a held low freezes it.
    always_ff @(posedge sys_clk) begin
        tb_reg <= timebase_pin;
        pl_reg <= common_plane_out;
        if (reset) begin
            rise_reg <= 8'h00;
            seen_reg <= 2'h0;
        end else if (common_plane_out != pl_reg) begin
            rise_reg <= 8'h00;
            seen_reg <= !common_plane_oe ? 2'h0 : (seen_reg == 2'h2 ? 2'h2 : seen_reg + 2'h1);
        end else begin
            rise_reg <= rise_reg + {7'h00, timebase_pin && !tb_reg};
            seen_reg <= common_plane_oe ? seen_reg : 2'h0;
        end
    end
    a_ack_after_req: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after a request");
    a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_reset_outputs_quiet: assert property (@(posedge sys_clk)
        reset |=> seg_out == 28'h000_0000 && !wb_ack_o && !common_plane_oe)
        else $error("outputs not cleared by reset");
    a_slave_release: assert property (@(posedge sys_clk) disable iff (reset)
        low_reg >= sdd_pkg::SDD_LOW_CYCLES + 6 |-> !common_plane_oe)
        else $error("plane driver on under a held low timebase");
    a_short_low_kept: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl_reg[1] && $past(ctrl_reg[1]) && $past(common_plane_oe)
        && low_reg < sdd_pkg::SDD_LOW_CYCLES - 4 |-> common_plane_oe)
        else $error("short timebase low released the plane");
    a_slave_follow: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl_reg[1] && low_reg >= sdd_pkg::SDD_LOW_CYCLES + 12
        && $past(common_plane_in, 2) != $past(common_plane_in, 3) |-> seg_out == ~$past(seg_out))
        else $error("segments did not follow the external plane");
    a_plane_divide: assert property (@(posedge sys_clk) disable iff (reset)
        common_plane_oe && seen_reg == 2'h2 && common_plane_out != pl_reg |-> rise_reg == sdd_pkg::SDD_PLANE_HALF)
        else $error("plane half period not 64 timebase rises");
    a_led_blank: assert property (@(posedge sys_clk) disable iff (reset)
        !ctrl_reg[1] && !$past(ctrl_reg[1]) && !$past(brightness) |-> seg_out == 28'h000_0000)
        else $error("LED segments lit with brightness low");
endmodule
bind sdd_top sdd_props chk_u (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .timebase_pin(timebase_pin), .common_plane_in(common_plane_in), .common_plane_out(common_plane_out),
    .common_plane_oe(common_plane_oe), .brightness(brightness), .seg_out(seg_out)
);
`default_nettype wire

//--- verification/sdd_source_model.sv
/* Digit source model: strobe source, processor select port and timebase.
   Assumes one caller at a time. */
`timescale 1ns/10ps
`default_nettype none
module sdd_source_model (
    input  wire logic       sys_clk,
    output logic      [3:0] value,
    output logic      [3:0] strobe,
    output logic      [1:0] addr,
    output logic            sel_a_n,
    output logic            sel_b_n,
    output logic            timebase
);
    logic run; // Timebase free-runs while high, else held low.
    // Idle levels, then a timebase of 8 cycles.
    initial begin
        value = 4'h0;
        strobe = 4'h0;
        addr = 2'b00;
        {sel_a_n, sel_b_n} = 2'b11;
        timebase = 1'b0;
        run = 1'b1;
        forever begin
            repeat (4) @(posedge sys_clk);
            timebase <= run ? ~timebase : 1'b0; // Lows far too short to disable.
        end
    end
    // Raise one digit strobe with the value.
    task automatic strobe_load(input int d, input logic [3:0] v);
        @(posedge sys_clk);
        value <= v;
        strobe[d] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        strobe[d] <= 1'b0;
        value <= ~v; // Released data does not keep its value.
        repeat (3) @(posedge sys_clk);
    endtask
    // Select cycle; with both clear only A is taken low.
    task automatic bus_load(input logic [1:0] a, input logic [3:0] v, input logic both);
        @(posedge sys_clk);
        value <= v;
        addr <= a;
        sel_a_n <= 1'b0;
        sel_b_n <= !both;
        repeat (3) @(posedge sys_clk);
        if (a[0])
            sel_a_n <= 1'b1;
        else
            sel_b_n <= 1'b1;
        @(posedge sys_clk);
        {sel_a_n, sel_b_n} <= 2'b11;
        value <= ~v;
        addr <= ~a;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
/* Bench for sdd_top: registers, both load schemes, LCD and LED, slave plane.
   Assumes the source model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        sys_clk, reset, brightness, ext_plane, p; // Bench pins.
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;    // Bus.
    logic [3:0]  wb_adr_i, val, stb;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        plane_out, plane_oe, plane_wire, sa_n, sb_n, tbase;
    logic [1:0]  addr;
    logic [27:0] seg_out, exp_dig; // Expected digit glyphs.
    int          mismatches, total_checks, n;
    // Shared plane pin: the device while enabled, else the bench.
    assign plane_wire = plane_oe ? plane_out : ext_plane;
    sdd_source_model src_u (.sys_clk(sys_clk), .value(val), .strobe(stb), .addr(addr),
        .sel_a_n(sa_n), .sel_b_n(sb_n), .timebase(tbase));
    sdd_top dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .value_bit_zero(val[0]),
        .value_bit_one(val[1]), .value_bit_two(val[2]), .value_bit_three(val[3]),
        .digit_one_strobe(stb[0]), .digit_two_strobe(stb[1]), .digit_three_strobe(stb[2]),
        .digit_four_strobe(stb[3]), .digit_addr_low(addr[0]), .digit_addr_high(addr[1]),
        .bus_select_a_n(sa_n), .bus_select_b_n(sb_n), .timebase_pin(tbase),
        .common_plane_in(plane_wire), .common_plane_out(plane_out), .common_plane_oe(plane_oe),
        .brightness(brightness), .seg_out(seg_out));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // One classic cycle, held until ack; a lost ack counts as a mismatch.
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        n = 0;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n == 50)
            mismatches++;
    endtask
    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] want);
        xfer(1'b0, adr, 32'h0000_0000);
        check(rd, want);
    endtask
    // Compare only across a span where the plane did not move.
    task automatic seg_chk();
        @(posedge sys_clk);
        p = plane_out;
        @(posedge sys_clk);
        #1;
        if (plane_out === p)
            check({4'h0, seg_out}, {4'h0, exp_dig ^ {28{p}}});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {reset, brightness, ext_plane, wb_cyc_i, wb_stb_i, wb_we_i} = 6'b110000;
        {wb_adr_i, wb_dat_i, exp_dig} = '0;
        {mismatches, total_checks} = '0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd_chk(4'h0, 32'h0000_0003);
        xfer(1'b1, 4'hC, 32'hFFFF_FFFF); // Unmapped write is dropped.
        rd_chk(4'hC, 32'h0000_0000);
        // Hex then restricted glyphs, strobe loading, LCD style.
        for (int m = 3; m >= 2; m--) begin
            xfer(1'b1, 4'h0, 32'(m));
            for (int v = 0; v < 16; v++) begin
                src_u.strobe_load(v % 4, 4'(v));
                exp_dig[7 * (v % 4) +: 7] = m[0] ? sdd_pkg::SDD_HEX_GLYPH[v] : sdd_pkg::SDD_CODEB_GLYPH[v];
                rd_chk(4'h8, {4'h0, exp_dig});
                seg_chk();
            end
        end
        xfer(1'b1, 4'h0, 32'h0000_0007); // Processor port.
        for (int a = 0; a < 4; a++) begin
            src_u.bus_load(2'(a), 4'(10 + a), 1'b1);
            exp_dig[7 * (3 - a) +: 7] = sdd_pkg::SDD_HEX_GLYPH[10 + a];
            rd_chk(4'h8, {4'h0, exp_dig});
        end
        src_u.bus_load(2'b11, 4'h8, 1'b0); // One select alone.
        src_u.strobe_load(0, 4'h8); // Strobes are ignored here.
        rd_chk(4'h8, {4'h0, exp_dig});
        xfer(1'b1, 4'h0, 32'h0000_0001); // LED style.
        repeat (4) @(posedge sys_clk);
        check({4'h0, seg_out}, {4'h0, exp_dig});
        check({31'h0, plane_oe}, 32'h0000_0000);
        for (int i = 0; i < 9; i++) begin
            @(posedge sys_clk);
            brightness <= i[0]; // Dimming by duty cycle.
        end
        repeat (3) @(posedge sys_clk);
        check({4'h0, seg_out}, 32'h0000_0000);
        brightness <= 1'b1;
        xfer(1'b1, 4'h0, 32'h0000_0003);
        src_u.run <= 1'b0;
        repeat (180) @(posedge sys_clk);
        rd_chk(4'h4, {30'h0, plane_out, 1'b0});
        repeat (100) @(posedge sys_clk);
        xfer(1'b0, 4'h4, 32'h0000_0000);
        check(rd & 32'h0000_0001, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            ext_plane <= ~ext_plane; // One external plane that every part follows.
            repeat (sdd_pkg::SDD_PLANE_HALF * 8) @(posedge sys_clk); // No faster than the own plane.
            check({4'h0, seg_out}, {4'h0, exp_dig ^ {28{ext_plane}}});
        end
        src_u.run <= 1'b1;
        // Skip two moves: leaving slave mode and the frozen divider phase give short halves.
        for (int k = 0; k < 2; k++) begin
            p = plane_out;
            while (plane_out === p)
                @(posedge sys_clk);
        end
        p = plane_out;
        n = 0;
        while (plane_out === p && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        check(32'(n), 32'(sdd_pkg::SDD_PLANE_HALF * 8));
        repeat (2) @(posedge sys_clk); // Let the checker see the last plane move.
        print_verdict();
    end
endmodule
`default_nettype wire
